// *** include/sab_pkg.sv ***
// Package for the serial address match and baud select block.
// Assumes one oscillator clock; all rates are enables on that clock.
package sab_pkg;
  localparam logic [7:0] SAB_ADDR_RST = 8'h00;
  localparam logic [7:0] SAB_MASK_RST = 8'h00;
  localparam int SAB_MODE0_DIV = 12;
  localparam int SAB_MODE2_DIV = 64;
  localparam int SAB_T1_DIV = 32;
  localparam int SAB_T2_DIV = 16;
  localparam int SAB_STATE_OSC = 2;
  localparam logic [8:0] SAB_T1_RELOAD_SPAN = 9'h100;
  localparam logic [1:0] SAB_MODE_SYNC = 2'h0;
  localparam logic [1:0] SAB_MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] SAB_MODE_FIXED9 = 2'h2;
  localparam logic [1:0] SAB_MODE_VAR9 = 2'h3;
  typedef enum logic [1:0]
  {
    SAB_BUF_EMPTY = 2'b01,
    SAB_BUF_FULL = 2'b10
  } sab_buf_type;
endpackage

// *** core/sab_core.sv ***
// Address recognition and baud-rate tick generation for the serial port.
// Assumes synchronous inputs; timer 1 overflow arrives as a one-cycle pulse.
// Behaviour
// (RULE_01) Broadcast address is address OR mask; zero bits are don't-care.
// (RULE_02) Reset clears address and mask, so every address frame matches.
// (RULE_03) Mode 0 shifts at oscillator divided by twelve, fixed.
// (RULE_04) Mode 2 runs at oscillator over 64, or over 32 when doubled.
// (RULE_05) Modes 1 and 3 default to timer 1 overflow over 32, doubled optionally.
// (RULE_06) Timer 1 auto-reload rate follows 256 minus reload value times 12.
// (RULE_07) Receive and transmit clock selects each pick timer 2 or timer 1.
// (RULE_08) Timer 2 clocking gives overflow rate over 16, no doubling.
// (RULE_09) Timer 2 overflow reloads the 16-bit counter from reload bytes.
// (RULE_10) In baud generator mode timer 2 overflow flag is not set.
// (RULE_11) External pin falling edge sets external flag, no reload there.
// (RULE_12) Timer 2 as baud timer increments every two oscillator periods.
// (RULE_13) Software stops timer 2 before touching count or reload bytes.
// (RULE_14) Software leaves count bytes alone while timer 2 runs as baud timer.
// (RULE_15) Transmit and receive run concurrently; modes 1/3 may differ.
// (RULE_16) Very low rates use software 16-bit timer 1 reloads.
// (RULE_17) Software disables timer 1 interrupt and sets its mode first.
// (RULE_18) Given address is the address with mask zeros as don't-care.
// (RULE_19) Multiproc modes 2/3 drop ninth-bit-clear frames; flag on address match.
// (RULE_20) Mode 1 recognition needs address match and a valid stop bit.
// (RULE_21) A frame matches if it agrees with given or broadcast address.
`timescale 1ns/100ps
`default_nettype none
module sab_core
  import sab_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [1:0] i_mode,
  input wire logic i_baud_double,
  input wire logic i_rx_clock_select,
  input wire logic i_tx_clock_select,
  input wire logic i_multiproc_enable,
  input wire logic i_addr_wr,
  input wire logic i_mask_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_timer1_overflow,
  input wire logic i_timer2_run,
  input wire logic i_timer2_counter_select,
  input wire logic i_timer2_count_tick,
  input wire logic i_timer2_external_pin,
  input wire logic i_timer2_external_enable,
  input wire logic i_timer2_flag_clr,
  input wire logic i_timer2_load_wr,
  input wire logic [15:0] i_timer2_load,
  input wire logic i_frame_valid,
  input wire logic [7:0] i_frame_data,
  input wire logic i_frame_bit9,
  output logic o_frame_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  output logic o_receive_flag_set,
  output logic o_timer2_external_flag,
  output logic o_timer2_overflow_flag,
  output logic o_timer2_irq,
  output logic [15:0] o_timer2_count,
  output logic o_tx_tick,
  output logic o_rx_tick,
  output logic o_shift_tick,
  output logic [7:0] o_slave_address,
  output logic [7:0] o_slave_address_mask
);
  logic rst_meta, rstn;
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      {rstn, rst_meta} <= 2'b00;
    else
      {rstn, rst_meta} <= {rst_meta, 1'b1};
  end

  // Address registers and matching
  logic [7:0] slave_address, slave_address_mask, next_slave_address, next_slave_address_mask;
  logic [7:0] bcast, cand;
  logic given_hit, bcast_hit, accept;
  always_comb
  begin
    next_slave_address = slave_address;
    next_slave_address_mask = slave_address_mask;
    if (i_addr_wr)
      next_slave_address = i_wdata;
    if (i_mask_wr)
      next_slave_address_mask = i_wdata;
  end
  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      {slave_address, slave_address_mask} <= {SAB_ADDR_RST, SAB_MASK_RST}; // see RULE_02
    else if (i_ce)
      {slave_address, slave_address_mask} <= {next_slave_address, next_slave_address_mask};
  end
  assign o_slave_address = slave_address;
  assign o_slave_address_mask = slave_address_mask;

  always_comb
  begin
    cand = i_frame_data;
    bcast = slave_address | slave_address_mask; // see RULE_01
    given_hit = ((cand ^ slave_address) & slave_address_mask) == 8'h00; // see RULE_18
    bcast_hit = ((cand ^ bcast) & bcast) == 8'h00; // see RULE_01
    accept = 1'b1;
    if (i_multiproc_enable && (i_mode == SAB_MODE_FIXED9 || i_mode == SAB_MODE_VAR9))
      accept = i_frame_bit9 && (given_hit || bcast_hit); // see RULE_19 RULE_21
    else if (i_multiproc_enable && i_mode == SAB_MODE_ASYNC8)
      accept = i_frame_bit9 && (given_hit || bcast_hit); // see RULE_20
  end

  // Two-entry buffer toward the receive register
  logic [7:0] buf_data [2];
  logic [7:0] next_buf0, next_buf1;
  logic [1:0] cnt, next_cnt;
  logic push, pop;
  assign o_frame_ready = i_ce && (cnt != 2'h2);
  assign push = i_frame_valid && o_frame_ready && accept;
  assign pop = o_rx_valid && i_rx_ready;
  assign o_rx_valid = (cnt != 2'h0);
  assign o_rx_data = buf_data[0];
  assign o_receive_flag_set = push;
  always_comb
  begin
    next_buf0 = buf_data[0];
    next_buf1 = buf_data[1];
    next_cnt = cnt;
    if (pop)
    begin
      next_buf0 = buf_data[1];
      next_cnt = next_cnt - 2'h1;
    end
    if (push)
    begin
      if (next_cnt == 2'h0)
        next_buf0 = i_frame_data;
      else
        next_buf1 = i_frame_data;
      next_cnt = next_cnt + 2'h1;
    end
  end
  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      {buf_data[0], buf_data[1], cnt} <= {8'h00, 8'h00, 2'h0};
    else if (i_ce)
      {buf_data[0], buf_data[1], cnt} <= {next_buf0, next_buf1, next_cnt};
  end

  // Timer 2 baud generator
  logic baud_gen;
  logic [15:0] t2, next_t2;
  logic state_ph, next_state_ph;
  logic ext_q, next_ext_q, ext_flag, next_ext_flag, ovf_flag, next_ovf_flag;
  logic t2_inc, t2_ovf;
  logic [3:0] t2_div, next_t2_div;
  assign baud_gen = i_rx_clock_select || i_tx_clock_select;
  always_comb
  begin
    next_state_ph = ~state_ph;
    // Timer mode counts each state time; counter mode uses external ticks
    t2_inc = i_timer2_run && (i_timer2_counter_select ? i_timer2_count_tick : state_ph); // see RULE_12
    t2_ovf = t2_inc && (t2 == 16'hffff);
    next_t2 = t2;
    if (i_timer2_load_wr)
      next_t2 = i_timer2_load;
    else if (t2_ovf && baud_gen)
      next_t2 = i_timer2_load; // see RULE_09
    else if (t2_inc)
      next_t2 = t2 + 16'h0001;
    next_ext_q = i_timer2_external_pin;
    next_ext_flag = ext_flag;
    next_ovf_flag = ovf_flag;
    if (i_timer2_flag_clr)
    begin
      next_ext_flag = 1'b0;
      next_ovf_flag = 1'b0;
    end
    // Set beats a simultaneous clear
    if (ext_q && !i_timer2_external_pin)
      next_ext_flag = 1'b1; // see RULE_11
    if (t2_ovf && !baud_gen)
      next_ovf_flag = 1'b1; // see RULE_10
    next_t2_div = t2_div;
    if (t2_ovf)
      next_t2_div = t2_div + 4'h1;
  end
  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      {t2, state_ph, ext_q, ext_flag, ovf_flag, t2_div} <=
        {16'h0000, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0};
    else if (i_ce)
      {t2, state_ph, ext_q, ext_flag, ovf_flag, t2_div} <=
        {next_t2, next_state_ph, next_ext_q, next_ext_flag, next_ovf_flag, next_t2_div};
  end
  assign o_timer2_count = t2;
  assign o_timer2_external_flag = ext_flag;
  assign o_timer2_overflow_flag = ovf_flag;
  assign o_timer2_irq = ovf_flag || (ext_flag && i_timer2_external_enable); // see RULE_11

  // Fixed dividers and timer 1 path
  logic [3:0] m0_cnt, next_m0_cnt;
  logic [5:0] m2_cnt, next_m2_cnt;
  logic [4:0] t1_cnt, next_t1_cnt;
  logic m0_tick, m2_tick, t1_tick, t2_tick;
  logic [5:0] m2_last;
  logic [4:0] t1_last;
  always_comb
  begin
    m0_tick = (m0_cnt == 4'(SAB_MODE0_DIV - 1)); // see RULE_03
    next_m0_cnt = m0_tick ? 4'h0 : m0_cnt + 4'h1;
    m2_last = i_baud_double ? 6'(SAB_MODE2_DIV / 2 - 1) : 6'(SAB_MODE2_DIV - 1);
    m2_tick = (m2_cnt >= m2_last); // see RULE_04
    next_m2_cnt = m2_tick ? 6'h00 : m2_cnt + 6'h01;
    // Timer 1 overflows, one per 12*(256-reload) cycles, divided by 32 or 16
    t1_last = i_baud_double ? 5'(SAB_T1_DIV / 2 - 1) : 5'(SAB_T1_DIV - 1);
    next_t1_cnt = t1_cnt;
    t1_tick = 1'b0;
    if (i_timer1_overflow)
    begin
      t1_tick = (t1_cnt >= t1_last); // see RULE_05 RULE_06
      next_t1_cnt = t1_tick ? 5'h00 : t1_cnt + 5'h01;
    end
    t2_tick = t2_ovf && (t2_div == 4'(SAB_T2_DIV - 1)); // see RULE_08
  end
  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      {m0_cnt, m2_cnt, t1_cnt} <= {4'h0, 6'h00, 5'h00};
    else if (i_ce)
      {m0_cnt, m2_cnt, t1_cnt} <= {next_m0_cnt, next_m2_cnt, next_t1_cnt};
  end

  logic next_tx_tick, next_rx_tick, next_shift_tick;
  always_comb
  begin
    next_shift_tick = (i_mode == SAB_MODE_SYNC) && m0_tick;
    case (i_mode)
      SAB_MODE_FIXED9:
      begin
        next_tx_tick = m2_tick; // see RULE_15
        next_rx_tick = m2_tick;
      end
      SAB_MODE_ASYNC8, SAB_MODE_VAR9:
      begin
        next_tx_tick = i_tx_clock_select ? t2_tick : t1_tick; // see RULE_07
        next_rx_tick = i_rx_clock_select ? t2_tick : t1_tick; // see RULE_07
      end
      default:
      begin
        next_tx_tick = 1'b0;
        next_rx_tick = 1'b0;
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
      {o_tx_tick, o_rx_tick, o_shift_tick} <= 3'b000;
    else if (i_ce)
      {o_tx_tick, o_rx_tick, o_shift_tick} <= {next_tx_tick, next_rx_tick, next_shift_tick};
  end

  chk_reset_clear: assert property (@(posedge i_clk) $rose(rstn) |-> slave_address == 8'h00) // see RULE_02
    else $error("address not cleared by reset");
  chk_no_ovf_flag: assert property (@(posedge i_clk) disable iff (!rstn)
    i_ce && t2_ovf && baud_gen |=> !$rose(ovf_flag)) // see RULE_10
    else $error("overflow flag set in baud mode");
  chk_t2_reload: assert property (@(posedge i_clk) disable iff (!rstn)
    i_ce && t2_ovf && baud_gen && !i_timer2_load_wr |=> t2 == $past(i_timer2_load)) // see RULE_09
    else $error("timer 2 missed reload");
  chk_ext_edge: assert property (@(posedge i_clk) disable iff (!rstn)
    i_ce && ext_q && !i_timer2_external_pin |=> ext_flag) // see RULE_11
    else $error("external edge lost");
  chk_mode0_gap: assert property (@(posedge i_clk) disable iff (!rstn)
    i_ce && m0_tick |=> !m0_tick [*8]) // see RULE_03
    else $error("mode 0 tick too early");
  chk_state_step: assert property (@(posedge i_clk) disable iff (!rstn)
    i_ce && i_timer2_run && !i_timer2_counter_select && state_ph |=> !t2_inc) // see RULE_12
    else $error("timer 2 stepped twice in a state");
  chk_mp_drop: assert property (@(posedge i_clk) disable iff (!rstn)
    i_multiproc_enable && i_mode[1] && !i_frame_bit9 |-> !o_receive_flag_set) // see RULE_19
    else $error("data frame accepted in multiproc");
  chk_bcast_hit: assert property (@(posedge i_clk) disable iff (!rstn)
    i_frame_valid && o_frame_ready && i_frame_bit9 && i_frame_data == 8'hff |-> o_receive_flag_set) // see RULE_21
    else $error("broadcast address not matched");
  cov_reload: cover property (@(posedge i_clk) t2_ovf && baud_gen);
  cov_match: cover property (@(posedge i_clk) o_receive_flag_set && i_multiproc_enable);
  cov_full: cover property (@(posedge i_clk) cnt == 2'h2 && i_frame_valid);
endmodule
`default_nettype wire

// *** verif/sab_node.sv ***
// Remote serial node model: hands received frames to the block.
// Assumes inputs sampled on the rising edge of i_clk.
`timescale 1ns/100ps
`default_nettype none
module sab_node
(
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_bit9
);
  int stuck = 0;
  initial
  begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_bit9 = 1'b0;
  end
  // Gap lets the node answer promptly or slowly
  task automatic send(input logic [7:0] d, input logic b9, input int gap);
    int k;
    k = 0;
    // At least one edge passes with valid low between two frames
    repeat (gap + 1) @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_data = d;
    o_bit9 = b9;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (i_ready !== 1'b1 && k < 200);
    if (i_ready !== 1'b1)
      stuck++;
    #1;
    // Released lines show the inverse, not the stale word
    o_valid = 1'b0;
    o_data = ~d;
    o_bit9 = ~b9;
  endtask
endmodule
`default_nettype wire

// *** verif/sab_core_tb_top.sv ***
// Self-checking bench for address recognition and rate ticks.
// Assumes the node model drives frames and this bench drains them.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module sab_core_tb_top;
  import sab_pkg::*;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, bd = 1'b0, rsel = 1'b0, tsel = 1'b0;
  logic [1:0] mode = 2'h3;
  logic mp = 1'b0, awr = 1'b0, mwr = 1'b0, t1 = 1'b0, t1on = 1'b0, run = 1'b0;
  logic pin = 1'b1, xen = 1'b0, fclr = 1'b0, lwr = 1'b0, rdy = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [15:0] load = 16'h0000;
  logic fv, fb9, frdy, rxv, rfs, xf, of, irq, txt, rxt, sht;
  logic [7:0] fd, rxd, sa, sm;
  logic [15:0] cnt;
  int t1c = 0, t1_gap = 4;
  int num_errors = 0, compares = 0, cyc = 0, flags = 0, tx_n, rx_n, sh_n, low_n;
  sab_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_mode(mode),
    .i_baud_double(bd), .i_rx_clock_select(rsel), .i_tx_clock_select(tsel),
    .i_multiproc_enable(mp), .i_addr_wr(awr), .i_mask_wr(mwr), .i_wdata(wd),
    .i_timer1_overflow(t1), .i_timer2_run(run), .i_timer2_counter_select(1'b0),
    .i_timer2_count_tick(1'b0), .i_timer2_external_pin(pin),
    .i_timer2_external_enable(xen), .i_timer2_flag_clr(fclr), .i_timer2_load_wr(lwr),
    .i_timer2_load(load), .i_frame_valid(fv), .i_frame_data(fd), .i_frame_bit9(fb9),
    .o_frame_ready(frdy), .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rdy),
    .o_receive_flag_set(rfs), .o_timer2_external_flag(xf), .o_timer2_overflow_flag(of),
    .o_timer2_irq(irq), .o_timer2_count(cnt), .o_tx_tick(txt), .o_rx_tick(rxt),
    .o_shift_tick(sht), .o_slave_address(sa), .o_slave_address_mask(sm));
  sab_node node (.i_clk(i_clk), .i_ready(frdy), .o_valid(fv), .o_data(fd), .o_bit9(fb9));
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  // Timer 1 overflow every t1_gap clocks; a long gap stands in for a software reload
  always @(posedge i_clk)
  begin
    t1c <= (t1c >= t1_gap - 1) ? 0 : t1c + 1;
    t1 <= t1on && t1c == 0;
    cyc++;
    if (rfs === 1'b1)
      flags++;
    if (cyc > 40000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    num_errors += node.stuck;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge i_clk);
    #1;
    s = 1'b0;
  endtask
  task automatic pop(input logic [7:0] e);
    int k;
    k = 0;
    while (rxv !== 1'b1 && k < 50)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    `CHK("rx_valid", 1'b1, rxv)
    `CHK("rx_data", e, rxd)
    rdy = 1'b1;
    @(posedge i_clk);
    #1;
    rdy = 1'b0;
    // Idle edge so a following pop never raises ready in the step it fell
    @(posedge i_clk);
    #1;
  endtask
  // Whole periods from any phase give an exact tick count
  task automatic meas(input int warm, input int n);
    repeat (warm) @(posedge i_clk);
    tx_n = 0;
    rx_n = 0;
    sh_n = 0;
    low_n = 0;
    repeat (n)
    begin
      @(posedge i_clk);
      #1;
      tx_n += int'(txt === 1'b1);
      rx_n += int'(rxt === 1'b1);
      sh_n += int'(sht === 1'b1);
      low_n += int'(cnt < 16'hfff0);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("slave_address", SAB_ADDR_RST, sa)
    `CHK("slave_mask", SAB_MASK_RST, sm)
    mp = 1'b1;
    node.send(8'h3c, 1'b1, 0);
    pop(8'h3c);
    wd = 8'h56;
    pulse(awr);
    wd = 8'hfc;
    pulse(mwr);
    flags = 0;
    node.send(8'h57, 1'b1, 0);
    node.send(8'h5a, 1'b1, 2);
    node.send(8'hfe, 1'b1, 0);
    `CHK("frame_ready", 1'b0, frdy)
    pop(8'h57);
    pop(8'hfe);
    node.send(8'hff, 1'b0, 0);
    node.send(8'h55, 1'b1, 0);
    pop(8'h55);
    mode = SAB_MODE_ASYNC8;
    node.send(8'h54, 1'b0, 0);
    node.send(8'hff, 1'b1, 1);
    pop(8'hff);
    `CHK("rx_valid", 1'b0, rxv)
    `CHK("flag_count", 4, flags)
    mp = 1'b0;
    mode = SAB_MODE_SYNC;
    meas(30, 10 * SAB_MODE0_DIV);
    `CHK("mode0_ticks", 10, sh_n)
    mode = SAB_MODE_FIXED9;
    meas(70, 10 * SAB_MODE2_DIV);
    `CHK("mode2_rx", 10, rx_n)
    `CHK("mode2_tx", 10, tx_n)
    bd = 1'b1;
    meas(70, 10 * SAB_MODE2_DIV);
    `CHK("mode2_dbl", 20, rx_n)
    mode = SAB_MODE_VAR9;
    t1on = 1'b1;
    meas(300, 4 * SAB_T1_DIV * 10);
    `CHK("t1_dbl", 20, tx_n)
    bd = 1'b0;
    meas(300, 4 * SAB_T1_DIV * 10);
    `CHK("t1_tx", 10, tx_n)
    `CHK("t1_rx", 10, rx_n)
    t1_gap = 10;
    meas(400, 10 * SAB_T1_DIV * 10);
    `CHK("t1_slow", 10, tx_n)
    t1_gap = 4;
    rsel = 1'b1;
    load = 16'hfff0;
    pulse(lwr);
    run = 1'b1;
    meas(1100, SAB_T2_DIV * 16 * SAB_STATE_OSC * 10);
    `CHK("t2_rx", 10, rx_n)
    `CHK("t1_tx_mix", 40, tx_n)
    `CHK("t2_reload", 0, low_n)
    bd = 1'b1;
    meas(600, SAB_T2_DIV * 16 * SAB_STATE_OSC * 10);
    `CHK("t2_nodbl", 10, rx_n)
    `CHK("t1_tx_dbl", 80, tx_n)
    `CHK("t2_ovf_flag", 1'b0, of)
    xen = 1'b1;
    pin = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("ext_flag", 1'b1, xf)
    `CHK("ext_irq", 1'b1, irq)
    `CHK("ext_noreload", 0, int'(cnt < 16'hfff0))
    pulse(fclr);
    @(posedge i_clk);
    #1;
    `CHK("ext_clr", 1'b0, xf)
    rsel = 1'b0;
    repeat (40) @(posedge i_clk);
    #1;
    `CHK("t2_ovf_set", 1'b1, of)
    end_of_test();
  end
endmodule
`default_nettype wire
